// file: design/aass_datapath.sv
`timescale 1ns/1ps
module aass_datapath
  import aass_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  aass_dp_if.dp dpi
);
  import aass_pkg::*;

  logic [ACC_W-1:0] acc_q, acc_d;
  logic [OPND_W-1:0] opnd_q, opnd_d;
  logic [ACC_W-1:0] sub_q, sub_d;
  logic zero_q, zero_d;

  // Ones' complement difference with end-around borrow
  function automatic logic [ACC_W:0] eas(input logic [ACC_W-1:0] m, input logic [ACC_W-1:0] s);
    logic [ACC_W:0] r;
    r = {1'b0, m} - {1'b0, s};
    if (r[ACC_W]) begin
      r[ACC_W-1:0] = r[ACC_W-1:0] - 72'h1; // RL19
    end
    return r;
  endfunction

  always_comb begin
    logic [ACC_W:0] r;
    logic [ACC_W-1:0] s;
    acc_d = acc_q;
    opnd_d = opnd_q;
    sub_d = sub_q;
    zero_d = 1'b0;
    r = '0;
    s = '0;
    if (dpi.wr) begin
      unique case (dpi.wsel)
        WR_ACC0: acc_d[31:0] = dpi.wdata;
        WR_ACC1: acc_d[63:32] = dpi.wdata;
        WR_ACC2: acc_d[71:64] = dpi.wdata[7:0];
        WR_OPND0: opnd_d[31:0] = dpi.wdata;
        WR_OPND1: opnd_d[35:32] = dpi.wdata[3:0];
      endcase
    end
    if (dpi.cpl_x) begin
      opnd_d = ~opnd_q; // RL6 RL11
    end
    if (dpi.xfer) begin
      // Toggle lower stages where operand holds zero; upper input toggles all RL4
      s = {(dpi.al_in ? {HALF_W{1'b1}} : {HALF_W{1'b0}}), ~opnd_q};
      sub_d = s;
      acc_d = acc_q ^ s;
    end
    if (dpi.probe) begin
      // Borrow resolution completes the partial sum RL4
      r = eas(acc_q ^ sub_q, sub_q);
      acc_d = r[ACC_W-1:0];
    end
    if (dpi.forced_end_borrow) begin
      r = {1'b0, acc_q} - 73'h1; // RL16
      acc_d = r[ACC_W-1:0];
      if (r[ACC_W]) begin
        acc_d = r[ACC_W-1:0] - 72'h1;
        zero_d = 1'b1; // RL18
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= ACC_RST;
      opnd_q <= OPND_RST;
      sub_q <= ACC_RST;
      zero_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      opnd_q <= opnd_d;
      sub_q <= sub_d;
      zero_q <= zero_d;
    end
  end

  assign dpi.acc = acc_q;
  assign dpi.opnd = opnd_q;
  assign dpi.set_zero = zero_q;
endmodule

// file: design/aass_dp_if.sv
`timescale 1ns/1ps
interface aass_dp_if;
  import aass_pkg::*;
  logic cpl_x;
  logic xfer;
  logic al_in;
  logic probe;
  logic forced_end_borrow;
  logic wr;
  aass_wsel_t wsel;
  logic [DATA_W-1:0] wdata;
  logic [ACC_W-1:0] acc;
  logic [OPND_W-1:0] opnd;
  logic set_zero;

  modport seq (output cpl_x, xfer, al_in, probe, forced_end_borrow, wr, wsel, wdata,
    input acc, opnd, set_zero);
  modport dp (input cpl_x, xfer, al_in, probe, forced_end_borrow, wr, wsel, wdata,
    output acc, opnd, set_zero);
endinterface

// file: design/aass_pkg.sv
package aass_pkg;
  localparam int ACC_W = 72;
  localparam int OPND_W = 36;
  localparam int HALF_W = 36;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ACC0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ACC1 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_ACC2 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_OPND0 = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_OPND1 = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_INT_EN = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_INT_CLR = 8'h24;

  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_AZERO = 1;
  localparam int ST_EXT = 2;
  // Interrupt fields
  localparam int IRQ_DONE = 0;
  localparam int IRQ_AZERO = 1;
  localparam int IRQ_W = 2;

  localparam logic [IRQ_W-1:0] INT_EN_RST = 2'h0;
  localparam logic [ACC_W-1:0] ACC_RST = 72'h0;
  localparam logic [OPND_W-1:0] OPND_RST = 36'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // Controlled clock pulse: one enable every CCP_DIV cycles
  localparam int CCP_DIV = 4;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_ADD = 3'h1,
    CMD_SUB = 3'h2,
    CMD_SPLIT_ADD = 3'h3,
    CMD_SPLIT_SUB = 3'h4,
    CMD_SUB_ONE = 3'h5
  } aass_cmd_t;

  typedef enum logic [2:0] {
    WR_ACC0 = 3'h0,
    WR_ACC1 = 3'h1,
    WR_ACC2 = 3'h2,
    WR_OPND0 = 3'h3,
    WR_OPND1 = 3'h4
  } aass_wsel_t;
endpackage

// file: design/aass_top.sv
// How it works
// RL1 - Set probe flop fires once, then clears
// RL2 - Start halts distributor; done pulse resumes it
// RL3 - Add: transfer, lower probe, then B probe
// RL4 - Transfer toggles zero stages; probe resolves borrows
// RL5 - Full subtract leaves difference, complemented operand
// RL6 - Subtract sets delayed add, complements operand
// RL7 - Delayed add drives transfer; upper when positive
// RL8 - B probe ends when extend flop clear
// RL9 - Split add treats operand positive, unchanged
// RL10 - Split add always issues upper input, probe
// RL11 - Split subtract flop, complement, transfer, probes
// RL12 - Split subtract never issues upper half
// RL13 - Split subtract leaves difference, complemented operand
// RL14 - Subtract-one decrements accumulator, operand untouched
// RL15 - Subtract-one sets decrement, extend, B flops
// RL16 - B probe forces end borrow into stage 0
// RL17 - C then D probe; D clears, signals done
// RL18 - Borrow out of top sets zero flag
// RL19 - Ones' complement with end-around borrow
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module aass_top
  import aass_pkg::*;
#(
  parameter int CCP_DIVIDE = CCP_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [DATA_W-1:0] hrdata,
  output logic sequence_done_pulse,
  output logic busy,
  output logic irq
);
  import aass_pkg::*;

  aass_dp_if dpi ();

  aass_datapath u_dp (
    .hclk(hclk),
    .hresetn(hresetn),
    .dpi(dpi)
  );

  // Controlled clock pulse divider
  logic [7:0] div_q, div_d;
  logic ccp;

  always_comb begin
    ccp = (div_q == 8'(CCP_DIVIDE - 1));
    div_d = ccp ? 8'h0 : div_q + 8'h1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 8'h0;
    end else begin
      div_q <= div_d;
    end
  end

  // AHB-Lite slave, zero wait states
  logic ap_wr_q, ap_wr_d;
  logic [ADDR_W-1:0] ap_addr_q, ap_addr_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic ap_valid;

  // Sequencer probe flops
  logic xfer_q, xfer_d;
  logic dadd_q, dadd_d;
  logic ssub_q, ssub_d;
  logic arp_q, arp_d;
  logic b_q, b_d;
  logic c_q, c_d;
  logic d_q, d_d;
  logic ext_q, ext_d;
  logic idec_q, idec_d;
  logic alc_q, alc_d;
  logic done_q, done_d;
  logic azero_q, azero_d;
  logic [IRQ_W-1:0] ist_q, ist_d;
  logic [IRQ_W-1:0] ien_q, ien_d;

  logic wr_hit;
  logic cmd_wr;
  aass_cmd_t cmd;

  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = 32'h0;
    unique case (a)
      OFF_STATUS: begin
        v[ST_BUSY] = busy;
        v[ST_AZERO] = azero_q;
        v[ST_EXT] = ext_q;
      end
      OFF_ACC0: v = dpi.acc[31:0];
      OFF_ACC1: v = dpi.acc[63:32];
      OFF_ACC2: v[7:0] = dpi.acc[71:64];
      OFF_OPND0: v = dpi.opnd[31:0];
      OFF_OPND1: v[3:0] = dpi.opnd[35:32];
      OFF_INT_STAT: v[IRQ_W-1:0] = ist_q;
      OFF_INT_EN: v[IRQ_W-1:0] = ien_q;
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  always_comb begin
    ap_valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    ap_wr_d = ap_valid && hwrite;
    ap_addr_d = ap_valid ? haddr : ap_addr_q;
    rdata_d = (ap_valid && !hwrite) ? read_mux(haddr) : 32'h0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h0;
      rdata_q <= 32'h0;
    end else begin
      ap_wr_q <= ap_wr_d;
      ap_addr_q <= ap_addr_d;
      rdata_q <= rdata_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign busy = xfer_q | dadd_q | ssub_q | arp_q | b_q | c_q | d_q | idec_q | ext_q;

  // Data writes only while idle, so a sequence never sees its operands move
  always_comb begin
    wr_hit = ap_wr_q && !busy;
    cmd_wr = wr_hit && (ap_addr_q == OFF_CMD);
    cmd = aass_cmd_t'(hwdata[2:0]);
    dpi.wr = 1'b0;
    dpi.wsel = WR_ACC0;
    dpi.wdata = hwdata;
    unique case (ap_addr_q)
      OFF_ACC0: begin
        dpi.wr = wr_hit;
        dpi.wsel = WR_ACC0;
      end
      OFF_ACC1: begin
        dpi.wr = wr_hit;
        dpi.wsel = WR_ACC1;
      end
      OFF_ACC2: begin
        dpi.wr = wr_hit;
        dpi.wsel = WR_ACC2;
      end
      OFF_OPND0: begin
        dpi.wr = wr_hit;
        dpi.wsel = WR_OPND0;
      end
      OFF_OPND1: begin
        dpi.wr = wr_hit;
        dpi.wsel = WR_OPND1;
      end
      default: dpi.wr = 1'b0;
    endcase
  end

  // Sequencer
  always_comb begin
    xfer_d = xfer_q;
    dadd_d = dadd_q;
    ssub_d = ssub_q;
    arp_d = arp_q;
    b_d = b_q;
    c_d = c_q;
    d_d = d_q;
    ext_d = ext_q;
    idec_d = idec_q;
    alc_d = alc_q;
    done_d = 1'b0;
    dpi.cpl_x = 1'b0;
    dpi.xfer = 1'b0;
    dpi.al_in = 1'b0;
    dpi.probe = 1'b0;
    dpi.forced_end_borrow = 1'b0;
    if (cmd_wr) begin // RL2
      unique case (cmd)
        CMD_ADD: begin
          xfer_d = 1'b1; // RL3
          alc_d = 1'b0;
        end
        CMD_SUB: begin
          dadd_d = 1'b1; // RL6
          dpi.cpl_x = 1'b1; // RL5
          alc_d = 1'b0;
        end
        CMD_SPLIT_ADD: begin
          xfer_d = 1'b1;
          alc_d = 1'b1; // RL10
        end
        CMD_SPLIT_SUB: begin
          ssub_d = 1'b1; // RL11
          dpi.cpl_x = 1'b1; // RL13
          alc_d = 1'b0;
        end
        CMD_SUB_ONE: begin
          idec_d = 1'b1; // RL14 RL15
          ext_d = 1'b1;
          b_d = 1'b1;
        end
        default: alc_d = alc_q;
      endcase
    end else if (ccp) begin
      // One probe per controlled pulse, highest step first RL1
      if (xfer_q || dadd_q || ssub_q) begin
        dpi.xfer = 1'b1; // RL7
        // Upper half follows sign, forced for split add, never for split subtract
        dpi.al_in = !ssub_q && (alc_q || !dpi.opnd[OPND_W-1]); // RL9 RL12
        xfer_d = 1'b0;
        dadd_d = 1'b0;
        ssub_d = 1'b0;
        arp_d = 1'b1;
      end else if (arp_q) begin
        dpi.probe = 1'b1; // RL4
        arp_d = 1'b0;
        b_d = 1'b1;
      end else if (b_q) begin
        b_d = 1'b0;
        dpi.forced_end_borrow = idec_q; // RL16
        c_d = idec_q;
        done_d = !ext_q; // RL8
      end else if (c_q) begin
        c_d = 1'b0; // RL17
        d_d = 1'b1;
      end else if (d_q) begin
        d_d = 1'b0;
        idec_d = 1'b0;
        ext_d = 1'b0;
        done_d = 1'b1; // RL17
      end
    end
  end

  // Zero flag: cleared by a new subtract-one, set wins over clear
  always_comb begin
    azero_d = azero_q;
    if (cmd_wr && cmd == CMD_SUB_ONE) begin
      azero_d = 1'b0;
    end
    if (dpi.set_zero) begin
      azero_d = 1'b1; // RL18
    end
  end

  // Interrupt status: sticky, write-one-to-clear, set wins
  always_comb begin
    ien_d = ien_q;
    ist_d = ist_q;
    if (ap_wr_q && ap_addr_q == OFF_INT_EN) begin
      ien_d = hwdata[IRQ_W-1:0];
    end
    if (ap_wr_q && ap_addr_q == OFF_INT_CLR) begin
      ist_d = ist_q & ~hwdata[IRQ_W-1:0];
    end
    if (done_q) begin
      ist_d[IRQ_DONE] = 1'b1;
    end
    if (dpi.set_zero) begin
      ist_d[IRQ_AZERO] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_q <= 1'b0;
      dadd_q <= 1'b0;
      ssub_q <= 1'b0;
      arp_q <= 1'b0;
      b_q <= 1'b0;
      c_q <= 1'b0;
      d_q <= 1'b0;
      ext_q <= 1'b0;
      idec_q <= 1'b0;
      alc_q <= 1'b0;
      done_q <= 1'b0;
      azero_q <= 1'b0;
      ist_q <= 2'h0;
      ien_q <= INT_EN_RST;
    end else begin
      xfer_q <= xfer_d;
      dadd_q <= dadd_d;
      ssub_q <= ssub_d;
      arp_q <= arp_d;
      b_q <= b_d;
      c_q <= c_d;
      d_q <= d_d;
      ext_q <= ext_d;
      idec_q <= idec_d;
      alc_q <= alc_d;
      done_q <= done_d;
      azero_q <= azero_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
    end
  end

  assign sequence_done_pulse = done_q; // RL2
  assign irq = |(ist_q & ien_q);
endmodule

// file: dv/aass_ahb_master.sv
`timescale 1ns/1ps
module aass_ahb_master
  import aass_pkg::*;
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [DATA_W-1:0] hrdata,
  output logic hsel,
  output logic [ADDR_W-1:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [DATA_W-1:0] hwdata
);
  import aass_pkg::*;

  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Enter just after a rising edge; returns at the edge that took the data
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule

// file: dv/aass_asserts.sv
`timescale 1ns/1ps
module aass_asserts
  import aass_pkg::*;
#(
  parameter int CCP_DIVIDE = CCP_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [DATA_W-1:0] hrdata,
  input wire logic sequence_done_pulse,
  input wire logic busy
);
  import aass_pkg::*;

  localparam int BUSY_MAX = 8 * CCP_DIVIDE;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence cmd_addr;
    hsel && hready && htrans[1] && hwrite && haddr == OFF_CMD && !busy;
  endsequence
  sequence good_code;
    !busy && hwdata[2:0] inside {[3'h1:3'h5]};
  endsequence

  chk_cmd_starts: assert property (cmd_addr ##1 good_code |=> busy)
    else $error("command did not start a sequence");
  chk_bad_code: assert property (cmd_addr ##1 (!busy && hwdata[2:0] > 3'h5) |=> !busy)
    else $error("unknown command started a sequence");
  chk_busy_bounded: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
    else $error("sequence did not end in time");
  chk_steps_min: assert property ($rose(busy) |-> busy [*3])
    else $error("sequence shorter than its steps");
  chk_done_pulse: assert property (sequence_done_pulse |=> !sequence_done_pulse)
    else $error("done pulse longer than one cycle");
  chk_done_after: assert property (sequence_done_pulse |-> !busy && ($past(busy) || $past(busy, 2)))
    else $error("done pulse without a finished sequence");
  chk_rdata_idle: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  chk_okay_resp: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_zero_wait: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");
endmodule

bind aass_top aass_asserts #(.CCP_DIVIDE(CCP_DIVIDE)) asserts_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .sequence_done_pulse(sequence_done_pulse), .busy(busy));

// file: dv/aass_top_tb.sv
`timescale 1ns/1ps
module aass_top_tb;
  import aass_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic hwrite;
  logic hreadyout;
  logic hresp;
  logic done;
  logic busy;
  logic irq;
  logic int_on;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [DATA_W-1:0] hwdata;
  logic [DATA_W-1:0] hrdata;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  localparam logic [ACC_W-1:0] A_INIT = 72'h123456789ABCDEF012;

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  aass_top #(.CCP_DIVIDE(2)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sequence_done_pulse(done), .busy(busy), .irq(irq));
  aass_ahb_master m_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize;
    end
  end

  task automatic check(input string what, input logic [ACC_W-1:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] nc;
    m_u.xfer(1'b1, a, d, nc);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    m_u.xfer(1'b0, a, 32'h0, d);
  endtask

  // Ones' complement difference with end-around borrow
  function automatic logic [ACC_W-1:0] osub(input logic [ACC_W-1:0] a, s);
    logic [ACC_W:0] d;
    d = {1'b0, a} - {1'b0, s};
    return d[ACC_W] ? d[ACC_W-1:0] - 72'h1 : d[ACC_W-1:0];
  endfunction

  task automatic load(input logic [ACC_W-1:0] a, input logic [OPND_W-1:0] x);
    wr(OFF_ACC0, a[31:0]);
    wr(OFF_ACC1, a[63:32]);
    wr(OFF_ACC2, {24'h0, a[71:64]});
    wr(OFF_OPND0, x[31:0]);
    wr(OFF_OPND1, {28'h0, x[35:32]});
  endtask

  task automatic run_cmd(input aass_cmd_t c, input logic [ACC_W-1:0] a_exp,
    input logic [OPND_W-1:0] x_exp, input logic zf);
    logic [DATA_W-1:0] w0;
    logic [DATA_W-1:0] w1;
    logic [DATA_W-1:0] w2;
    int n;
    wr(OFF_CMD, {29'h0, c});
    // Lands while busy, so it must be dropped
    wr(OFF_ACC0, 32'hFFFFFFFF);
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    check("done", ACC_W'(done), 72'h1);
    @(posedge hclk);
    rd(OFF_ACC0, w0);
    rd(OFF_ACC1, w1);
    rd(OFF_ACC2, w2);
    check("acc", {w2[7:0], w1, w0}, a_exp);
    rd(OFF_OPND0, w0);
    rd(OFF_OPND1, w1);
    check("opnd", ACC_W'({w1[3:0], w0}), ACC_W'(x_exp));
    rd(OFF_STATUS, w0);
    check("status", ACC_W'(w0[2:0]), ACC_W'({1'b0, zf, 1'b0}));
    rd(OFF_INT_STAT, w0);
    check("int_stat", ACC_W'(w0[1:0]), ACC_W'({zf, 1'b1}));
    check("irq", ACC_W'(irq), ACC_W'(int_on));
    wr(OFF_INT_CLR, 32'h3);
    @(posedge hclk);
    check("irq cleared", ACC_W'(irq), 72'h0);
    $display("test command %0d done", c);
  endtask

  initial begin
    logic [DATA_W-1:0] v;
    logic [OPND_W-1:0] xs [2];
    logic [OPND_W-1:0] xc;
    logic up;
    hresetn = 1'b0;
    int_on = 1'b0;
    xs = '{36'h000000005, 36'hFFFFFFFF0};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFF_ACC0, v);
    check("acc0 reset", ACC_W'(v), 72'h0);
    rd(OFF_INT_EN, v);
    check("int_en reset", ACC_W'(v), 72'h0);
    rd(8'hFC, v);
    check("unmapped", ACC_W'(v), 72'h0);
    wr(OFF_CMD, 32'h7);
    @(posedge hclk);
    check("bad command", ACC_W'(busy), 72'h0);
    $display("test reset and refusals done");
    for (int c = 1; c <= 4; c++) begin
      foreach (xs[i]) begin
        xc = (c == 2 || c == 4) ? ~xs[i] : xs[i];
        up = (c == 3) || (c < 3 && !xc[35]);
        load(A_INIT, xs[i]);
        run_cmd(aass_cmd_t'(c), osub(A_INIT, {up ? 36'hFFFFFFFFF : 36'h0, ~xc}), xc, 1'b0);
        wr(OFF_INT_EN, 32'h3);
        int_on = 1'b1;
      end
    end
    load(72'h5, 36'h123456789);
    run_cmd(CMD_SUB_ONE, 72'h4, 36'h123456789, 1'b0);
    load(72'h0, 36'h0);
    run_cmd(CMD_SUB_ONE, 72'hFFFFFFFFFFFFFFFFFE, 36'h0, 1'b1);
    // A fresh subtract-one must drop the zero flag left by the last one
    load(72'h3, 36'h0);
    run_cmd(CMD_SUB_ONE, 72'h2, 36'h0, 1'b0);
    summarize;
  end
endmodule
